// ===== include/dvm_pkg.sv
/*
 * package for the value mapper: limits, defaults, config carriers.
 * assumes signed 16-bit pure integers within +/-30000.
 */
package dvm_pkg;

    // -------------------------------------------------------------
    // pure number limits and widths
    // -------------------------------------------------------------
    localparam int VAL_W = 16;
    localparam logic signed [15:0] PURE_MAX = 16'sd30000;
    localparam logic signed [15:0] PURE_MIN = -16'sd30000;
    localparam logic signed [15:0] LEVEL_MAX = 16'sd30000; // +300.00%
    localparam logic signed [15:0] LEVEL_MIN = -16'sd30000; // -300.00%
    localparam int NUM_BIDIR = 4;
    localparam int NUM_OUT = 3;
    localparam int NUM_POST = 4;
    localparam int STR_W = 8;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic signed [15:0] DEF_HIGH_LEVEL = 16'sh0001; // 0.01%
    localparam logic signed [15:0] DEF_LOW_LEVEL = 16'sh0000; // 0.00%
    localparam logic signed [15:0] DEF_THRESHOLD = 16'sh0000; // 0.00%
    localparam logic [1:0] DEF_OUT_SRC = 2'h0; // status flag input
    localparam logic signed [15:0] MUX_MAX_CHOICE = 16'sh0004;

    // one output comparator configuration
    typedef struct packed {
        logic rectify_en;
        logic invert_en;
        logic signed [15:0] threshold;
    } dvm_cmp_cfg_type;

    // one bidirectional terminal input configuration
    typedef struct packed {
        logic drive_en;
        logic signed [15:0] high_level;
        logic signed [15:0] input_low_level;
    } dvm_bidir_cfg_type;

endpackage

// ===== src/dvm_clamp.sv
/*
 * clamp of a pure integer to a target range.
 * assumes min_val <= max_val; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module dvm_clamp (
    input wire logic signed [15:0] in_val,  // incoming pure integer
    input wire logic signed [15:0] min_val, // target lower limit
    input wire logic signed [15:0] max_val, // target upper limit
    output logic signed [15:0] out_val      // clamped value
);

    // -------------------------------------------------------------
    // limit to target
    // -------------------------------------------------------------
    always_comb begin
        if (in_val > max_val) begin
            out_val = max_val;
        end else if (in_val < min_val) begin
            out_val = min_val;
        end else begin
            out_val = in_val;
        end
    end

endmodule
`default_nettype wire

// ===== src/dvm_compare.sv
/*
 * output processing of one terminal: rectify, compare, invert.
 * assumes a signed pure-integer source; combinational, registered downstream.
 */
`timescale 1ns/1ps
`default_nettype none

module dvm_compare (
    input wire logic signed [15:0] src_val,     // source pure integer
    input wire dvm_pkg::dvm_cmp_cfg_type cfg,   // rectify/invert/threshold
    output logic result                         // processed binary result
);

    logic signed [16:0] stage_val;
    logic cmp_hi;

    // -------------------------------------------------------------
    // rectifier stage, then strict comparator, then inverter
    // -------------------------------------------------------------
    always_comb begin
        if (cfg.rectify_en && src_val < 0) begin
            stage_val = -{src_val[15], src_val};
        end else begin
            stage_val = {src_val[15], src_val};
        end
        cmp_hi = stage_val > 17'(cfg.threshold);
        result = cmp_hi ^ cfg.invert_en;
    end

endmodule
`default_nettype wire

// ===== src/dvm_mapper.sv
/*
 * value mapper: four two-way and three output-only terminals, staging
 * posts, changeover and pure-number transfer helpers.
 * assumes asynchronous pins, one clock, same-clock configuration ports.
 */
//
// Functional notes
// - bidir terminal low selects its input_low_level, range +/-300.00%.
// - defaults: input mode, high 0.01%, low 0.00%, preset destination.
// - bidir output result computed even when driver disabled.
// - rectify on: compare magnitude of source.
// - rectify off: compare signed source directly.
// - comparator high only when strictly above threshold.
// - invert enable flips comparator result for pin and copy.
// - each output-only terminal result published internally.
// - defaults: threshold 0.00%, source from preset status flag.
// - block output active when linked to a post, value visible there.
// - zero is logic low, any nonzero value logic high.
// - linear values are signed integers within +/-30000.
// - pure integer is displayed value without point and units.
// - out-of-range transfers clamp to target limit.
// - two-state encodings: high/enabled/motor2/invert are 1.
// - binary string: rightmost bit most significant.
// - multi-state choices map to 0..4 in order.
// - changeover passes high input when control is 1, else low.
`timescale 1ns/1ps
`default_nettype none

module dvm_mapper (
    input wire logic clk_sys,                      // processing clock
    input wire logic rst_n,                        // async reset, low
    input wire logic clk_en,                       // freezes state when low
    input wire logic defaults_restore,             // load default settings
    // bidirectional terminals
    input wire logic [3:0] bidir_terminal_in,      // pin levels
    output logic [3:0] bidir_terminal_out,         // pin drive level
    output logic [3:0] bidir_terminal_oe,          // pin drive enable
    input wire logic [3:0] bidir_drive_en,         // output mode enable
    input wire logic [3:0] bidir_cfg_wr,           // load bidir config
    input wire dvm_pkg::dvm_bidir_cfg_type bidir_cfg_in, // config value
    input wire logic [3:0] bidir_cmp_wr,           // load bidir comparator
    input wire logic [3:0] out_cmp_wr,             // load output comparator
    input wire dvm_pkg::dvm_cmp_cfg_type cmp_cfg_in, // comparator value
    input wire logic [1:0] src_sel_in,             // source_link choice
    // sources for the output processing
    input wire logic [2:0] status_flag,            // preset status flags
    input wire logic signed [15:0] linear_src,     // linear source value
    // destinations
    output logic signed [15:0] destination_link [4], // bidir input values
    output logic [3:0] destination_logic,          // same, as logic
    output logic [3:0] internal_output_result,     // bidir hidden results
    output logic [2:0] output_only_terminal,       // output pin levels
    output logic [2:0] out_result,                 // published copies
    // staging posts
    input wire logic [3:0] post_link_en,           // block linked to post
    input wire logic [1:0] post_src_sel [4],       // which block output
    output logic [3:0] post_active,                // post has a source
    output logic signed [15:0] analog_post [4],    // post linear value
    output logic [3:0] digital_post,               // post logic value
    // pure-number transfer helpers
    input wire logic signed [15:0] xfer_val,       // value to transfer
    input wire logic signed [15:0] xfer_min,       // target minimum
    input wire logic signed [15:0] xfer_max,       // target maximum
    output logic signed [15:0] xfer_out,           // clamped value
    input wire logic [7:0] bin_string,             // leftmost bit = bit 7
    output logic [15:0] bin_decimal,               // decimal equivalent
    input wire logic signed [15:0] multi_src,      // multi-state source
    output logic [2:0] multi_choice,               // choice 0..4
    input wire logic co_ctrl,                      // changeover control
    input wire logic signed [15:0] co_high,        // changeover high input
    input wire logic signed [15:0] co_low,         // changeover low input
    output logic signed [15:0] co_out              // changeover output
);

    // -------------------------------------------------------------
    // reset release and pin synchronisers
    // -------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    // two-flop reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // two-flop pin synchroniser
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else if (clk_en) begin
            pin_meta <= bidir_terminal_in;
            pin_sync <= pin_meta;
        end
    end

    // -------------------------------------------------------------
    // configuration storage
    // -------------------------------------------------------------
    dvm_pkg::dvm_bidir_cfg_type bidir_cfg [4];
    dvm_pkg::dvm_cmp_cfg_type bidir_cmp [4];
    dvm_pkg::dvm_cmp_cfg_type out_cmp [3];
    logic [1:0] out_src_sel [3];
    logic signed [15:0] cfg_lo_clamped;
    logic signed [15:0] cfg_hi_clamped;

    // levels limited to +/-300.00% before storage
    dvm_clamp u_lo_clamp (
        .in_val(bidir_cfg_in.input_low_level),
        .min_val(dvm_pkg::LEVEL_MIN),
        .max_val(dvm_pkg::LEVEL_MAX),
        .out_val(cfg_lo_clamped)
    );

    dvm_clamp u_hi_clamp (
        .in_val(bidir_cfg_in.high_level),
        .min_val(dvm_pkg::LEVEL_MIN),
        .max_val(dvm_pkg::LEVEL_MAX),
        .out_val(cfg_hi_clamped)
    );

    // bidir input levels and comparator settings
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
                bidir_cfg[i] <= '{1'b0, dvm_pkg::DEF_HIGH_LEVEL,
                    dvm_pkg::DEF_LOW_LEVEL};
                bidir_cmp[i] <= '{1'b0, 1'b0, dvm_pkg::DEF_THRESHOLD};
            end
        end else if (clk_en) begin
            for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
                if (defaults_restore) begin
                    bidir_cfg[i] <= '{1'b0, dvm_pkg::DEF_HIGH_LEVEL,
                        dvm_pkg::DEF_LOW_LEVEL};
                    bidir_cmp[i] <= '{1'b0, 1'b0, dvm_pkg::DEF_THRESHOLD};
                end else begin
                    bidir_cfg[i].drive_en <= bidir_drive_en[i];
                    if (bidir_cfg_wr[i]) begin
                        bidir_cfg[i].high_level <= cfg_hi_clamped;
                        bidir_cfg[i].input_low_level <= cfg_lo_clamped;
                    end
                    if (bidir_cmp_wr[i]) begin
                        bidir_cmp[i] <= cmp_cfg_in;
                    end
                end
            end
        end
    end

    // output-only terminal settings
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < dvm_pkg::NUM_OUT; i++) begin
                out_cmp[i] <= '{1'b0, 1'b0, dvm_pkg::DEF_THRESHOLD};
                out_src_sel[i] <= dvm_pkg::DEF_OUT_SRC;
            end
        end else if (clk_en) begin
            for (int i = 0; i < dvm_pkg::NUM_OUT; i++) begin
                if (defaults_restore) begin
                    out_cmp[i] <= '{1'b0, 1'b0, dvm_pkg::DEF_THRESHOLD};
                    out_src_sel[i] <= dvm_pkg::DEF_OUT_SRC;
                end else if (out_cmp_wr[i]) begin
                    out_cmp[i] <= cmp_cfg_in;
                    out_src_sel[i] <= src_sel_in;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // source selection and output processing
    // -------------------------------------------------------------
    logic signed [15:0] out_src [3];
    logic signed [15:0] bidir_src [4];
    logic [2:0] next_out_result;
    logic [3:0] next_bidir_result;

    // source_link: 0 own status flag, 1 linear, 2/3 flag as 0/1 constant
    always_comb begin
        for (int i = 0; i < dvm_pkg::NUM_OUT; i++) begin
            unique case (out_src_sel[i])
                2'h0: out_src[i] = {15'h0000, status_flag[i]};
                2'h1: out_src[i] = linear_src;
                2'h2: out_src[i] = 16'sh0000;
                2'h3: out_src[i] = 16'sh0001;
            endcase
        end
        // bidir outputs watch the linear source
        for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
            bidir_src[i] = linear_src;
        end
    end

    genvar g;
    generate
        for (g = 0; g < dvm_pkg::NUM_OUT; g++) begin : g_out
            dvm_compare u_cmp (
                .src_val(out_src[g]),
                .cfg(out_cmp[g]),
                .result(next_out_result[g])
            );
        end
        for (g = 0; g < dvm_pkg::NUM_BIDIR; g++) begin : g_bidir
            dvm_compare u_cmp (
                .src_val(bidir_src[g]),
                .cfg(bidir_cmp[g]),
                .result(next_bidir_result[g])
            );
        end
    endgenerate

    // registered results, independent of drive enable
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_result <= 3'h0;
            output_only_terminal <= 3'h0;
            internal_output_result <= 4'h0;
            bidir_terminal_out <= 4'h0;
            bidir_terminal_oe <= 4'h0;
        end else if (clk_en) begin
            out_result <= next_out_result;
            output_only_terminal <= next_out_result;
            internal_output_result <= next_bidir_result;
            bidir_terminal_out <= next_bidir_result;
            for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
                bidir_terminal_oe[i] <= bidir_cfg[i].drive_en;
            end
        end
    end

    // -------------------------------------------------------------
    // input value selection toward destination_link
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
                destination_link[i] <= dvm_pkg::DEF_LOW_LEVEL;
            end
            destination_logic <= 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < dvm_pkg::NUM_BIDIR; i++) begin
                if (pin_sync[i]) begin
                    destination_link[i] <= bidir_cfg[i].high_level;
                    destination_logic[i] <= bidir_cfg[i].high_level != 0;
                end else begin
                    destination_link[i] <= bidir_cfg[i].input_low_level;
                    destination_logic[i] <= bidir_cfg[i].input_low_level != 0;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // staging posts
    // -------------------------------------------------------------
    logic signed [15:0] post_in [4];

    // block output choice: 0..2 output results, 3 bidir 0 destination
    always_comb begin
        for (int i = 0; i < dvm_pkg::NUM_POST; i++) begin
            unique case (post_src_sel[i])
                2'h0: post_in[i] = {15'h0000, next_out_result[0]};
                2'h1: post_in[i] = {15'h0000, next_out_result[1]};
                2'h2: post_in[i] = {15'h0000, next_out_result[2]};
                2'h3: post_in[i] = destination_link[0];
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < dvm_pkg::NUM_POST; i++) begin
                analog_post[i] <= 16'sh0000;
            end
            digital_post <= 4'h0;
            post_active <= 4'h0;
        end else if (clk_en) begin
            post_active <= post_link_en;
            for (int i = 0; i < dvm_pkg::NUM_POST; i++) begin
                if (post_link_en[i]) begin
                    analog_post[i] <= post_in[i];
                    digital_post[i] <= post_in[i] != 0;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // pure-number transfer helpers
    // -------------------------------------------------------------
    logic signed [15:0] xfer_pure;
    logic signed [15:0] xfer_clamped;
    logic signed [15:0] multi_clamped;
    logic [15:0] next_bin_decimal;

    // the transfer value is first held within the +/-30000 system range
    dvm_clamp u_pure_clamp (
        .in_val(xfer_val),
        .min_val(dvm_pkg::PURE_MIN),
        .max_val(dvm_pkg::PURE_MAX),
        .out_val(xfer_pure)
    );

    dvm_clamp u_xfer_clamp (
        .in_val(xfer_pure),
        .min_val(xfer_min),
        .max_val(xfer_max),
        .out_val(xfer_clamped)
    );

    dvm_clamp u_multi_clamp (
        .in_val(multi_src),
        .min_val(16'sh0000),
        .max_val(dvm_pkg::MUX_MAX_CHOICE),
        .out_val(multi_clamped)
    );

    // reversed bit order: leftmost bit carries weight one
    always_comb begin
        next_bin_decimal = 16'h0000;
        for (int i = 0; i < dvm_pkg::STR_W; i++) begin
            next_bin_decimal[i] = bin_string[dvm_pkg::STR_W - 1 - i];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xfer_out <= 16'sh0000;
            bin_decimal <= 16'h0000;
            multi_choice <= 3'h0;
            co_out <= 16'sh0000;
        end else if (clk_en) begin
            xfer_out <= xfer_clamped;
            bin_decimal <= next_bin_decimal;
            multi_choice <= multi_clamped[2:0];
            co_out <= co_ctrl ? co_high : co_low;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/dvm_wiring.sv
/* wiring at the four two-way terminals.
   assumes a diode drive: a contact can pull a low output high. */
`timescale 1ns/1ps
`default_nettype none
module dvm_wiring (
    input wire logic [3:0] ext_level, // machine contact state
    input wire logic [3:0] pin_out, // device drive level
    input wire logic [3:0] pin_oe, // device drive enable
    output logic [3:0] pin_level // wired terminal level
);
    // wired-or of contacts and enabled device drivers
    assign pin_level = ext_level | (pin_oe & pin_out);
endmodule
`default_nettype wire

// ===== testbench/dvm_checker.sv
/* port assertions for dvm_mapper.
   assumes a bind and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dvm_checker (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset, low
    input wire logic clk_en, // advance enable
    input wire logic co_ctrl, // c/o control
    input wire logic signed [15:0] co_high, // c/o high
    input wire logic signed [15:0] co_low, // c/o low
    input wire logic signed [15:0] co_out, // c/o out
    input wire logic [7:0] bin_string, // string
    input wire logic [15:0] bin_decimal, // decimal
    input wire logic signed [15:0] multi_src, // multi in
    input wire logic [2:0] multi_choice, // choice
    input wire logic signed [15:0] xfer_val, // transfer in
    input wire logic signed [15:0] xfer_min, // lower limit
    input wire logic signed [15:0] xfer_max, // upper limit
    input wire logic signed [15:0] xfer_out, // clamped
    input wire logic signed [15:0] destination_link [4], // dest
    input wire logic [3:0] destination_logic, // dest logic
    input wire logic [2:0] output_only_terminal, // out pins
    input wire logic [2:0] out_result, // out copies
    input wire logic [3:0] bidir_terminal_out, // bidir drive
    input wire logic [3:0] internal_output_result, // hidden copy
    input wire logic [3:0] post_link_en, // post link
    input wire logic [3:0] post_active // post active
);
    // ------------------
    // settle counter
    // ------------------
    logic [2:0] up_cnt;
    logic live;
    logic [7:0] rev_str;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    assign live = (up_cnt >= 3'h3);
    assign rev_str = {<<{bin_string}};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_co;
        live && $past(clk_en) |-> co_out ==
            ($past(co_ctrl) ? $past(co_high) : $past(co_low));
    endproperty
    a_co: assert property (p_co) else $error("c/o output wrong");
    property p_bin;
        live && $past(clk_en) |-> bin_decimal == {8'h00, $past(rev_str)};
    endproperty
    a_bin: assert property (p_bin) else $error("bit order wrong");
    property p_multi;
        live && $past(clk_en) |-> multi_choice == ($past(multi_src) < 0 ?
            3'h0 : $past(multi_src) > 4 ? 3'h4 : $past(multi_src[2:0]));
    endproperty
    a_multi: assert property (p_multi) else $error("choice wrong");
    property p_xfer;
        live && $past(clk_en) |-> xfer_out ==
            ($past(xfer_val) > $past(xfer_max) ? $past(xfer_max) :
            $past(xfer_val) < $past(xfer_min) ? $past(xfer_min) :
            $past(xfer_val));
    endproperty
    a_xfer: assert property (p_xfer) else $error("clamp wrong");
    property p_dlogic;
        live |-> destination_logic == {destination_link[3] != 0,
            destination_link[2] != 0, destination_link[1] != 0,
            destination_link[0] != 0};
    endproperty
    a_dlogic: assert property (p_dlogic) else $error("logic wrong");
    property p_copy;
        live |-> out_result == output_only_terminal;
    endproperty
    a_copy: assert property (p_copy) else $error("copy differs");
    property p_hidden;
        live |-> internal_output_result == bidir_terminal_out;
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden differs");
    property p_active;
        live && $past(clk_en) |-> post_active == $past(post_link_en);
    endproperty
    a_active: assert property (p_active) else $error("post wrong");
endmodule
`default_nettype wire

// ===== testbench/dvm_mapper_tb.sv
/* self-checking bench for dvm_mapper.
   assumes package, design, wiring and checker alongside. */
`timescale 1ns/1ps
`default_nettype none
module dvm_mapper_tb;
    typedef struct packed {
        logic [3:0] what;
        logic [15:0] val;
    } dvm_note_type;
    logic clk_sys = 1'b0;
    logic rst_n, clk_en, defaults_restore, co_ctrl;
    logic [3:0] ext_level, bidir_terminal_in, bidir_terminal_out;
    logic [3:0] bidir_terminal_oe, bidir_drive_en, bidir_cfg_wr;
    logic [3:0] bidir_cmp_wr, destination_logic, internal_output_result;
    logic [3:0] post_link_en, post_active, digital_post;
    logic [2:0] out_cmp_wr, status_flag, output_only_terminal, out_result;
    logic [2:0] multi_choice;
    logic [1:0] src_sel_in;
    logic [1:0] post_src_sel [4];
    dvm_pkg::dvm_bidir_cfg_type bidir_cfg_in;
    dvm_pkg::dvm_cmp_cfg_type cmp_cfg_in;
    logic signed [15:0] linear_src, xfer_val, xfer_min, xfer_max, xfer_out;
    logic signed [15:0] co_high, co_low, co_out, multi_src, e, c;
    logic signed [15:0] destination_link [4];
    logic signed [15:0] analog_post [4];
    logic [7:0] bin_string, rb;
    logic [15:0] bin_decimal;
    logic [31:0] r;
    logic [1:0] ri [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
    logic signed [15:0] lv [5] = '{16'sd101, 16'sd100, -16'sd101,
        -16'sd101, 16'sd101};
    logic ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    int seed = 32'hfc38;
    int n_mismatch = 0;
    int check_count = 0;
    dvm_note_type notes [$];
    dvm_note_type nt;
    dvm_mapper dvm_mapper_i (.*);
    dvm_wiring dvm_wiring_i (
        .ext_level, .pin_out(bidir_terminal_out),
        .pin_oe(bidir_terminal_oe), .pin_level(bidir_terminal_in)
    );
    always #20 clk_sys = ~clk_sys;
    // ------------------
    // notes, compare, verdict
    // ------------------
    task automatic note(input logic [3:0] w, input logic [15:0] v);
        notes.push_back('{w, v});
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check16(input string nm, input logic [15:0] exv,
            input logic [15:0] got);
        check_count++;
        if (got !== exv) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exv, got);
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // compare pending notes after each rising edge
    always @(posedge clk_sys) begin
        #1;
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.what)
                4'h0: check16("co_out", nt.val, co_out);
                4'h1: check16("bin_decimal", nt.val, bin_decimal);
                4'h2: check16("multi_choice", nt.val, {13'h0, multi_choice});
                4'h3: check16("xfer_out", nt.val, xfer_out);
                4'h4: check16("out_result", nt.val, {13'h0, out_result});
                4'h5: check16("dest0", nt.val, destination_link[0]);
                4'h6: check16("post0", nt.val, analog_post[0]);
                4'h8: check16("oe_hidden", nt.val,
                    {8'h0, bidir_terminal_oe, internal_output_result});
                default: check16("posts", nt.val,
                    {8'h0, digital_post, post_active});
            endcase
        end
    end
    // hang guard
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
    // main sequence, inputs change at falling edges
    initial begin
        {rst_n, clk_en, defaults_restore, co_ctrl} = 4'h4;
        {ext_level, bidir_drive_en, bidir_cfg_wr, bidir_cmp_wr} = 16'h0;
        {out_cmp_wr, src_sel_in, status_flag, post_link_en} = 12'h0;
        post_src_sel = '{default: 2'h3};
        {bidir_cfg_in, cmp_cfg_in} = '0;
        {linear_src, xfer_val, co_high, co_low, multi_src} = 80'h0;
        {xfer_min, xfer_max, bin_string} = {-16'sd200, 16'sd6000, 8'h00};
        step(4);
        rst_n = 1'b1;
        step(3);
        status_flag = 3'h5;
        ext_level = 4'h1;
        step(2);
        note(4'h4, 16'h0005);
        note(4'h5, 16'h0001);
        step(1);
        for (int i = 0; i < 5; i++) begin
            cmp_cfg_in = '{ri[i][1], ri[i][0], 16'sd100};
            {src_sel_in, out_cmp_wr, bidir_cmp_wr} = {2'h1, 3'h1, 4'hf};
            step(1);
            {out_cmp_wr, bidir_cmp_wr} = 7'h0;
            linear_src = lv[i];
            note(4'h4, 16'h0004 | {15'h0, ex[i]});
            note(4'h8, {12'h0, {4{ex[i]}}});
            step(1);
        end
        bidir_drive_en = 4'h2;
        step(1);
        note(4'h8, 16'h0020);
        bidir_drive_en = 4'h0;
        bidir_cfg_in = '{1'b0, 16'sh7fff, -16'sd500};
        {bidir_cfg_wr, post_link_en} = 8'h11;
        step(1);
        {bidir_cfg_wr, ext_level} = 8'h0;
        step(2);
        note(4'h5, -16'sd500);
        step(1);
        note(4'h6, -16'sd500);
        note(4'h9, 16'h0011);
        ext_level = 4'h1;
        step(2);
        note(4'h5, 16'sd30000);
        step(1);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            co_ctrl = r[0];
            co_high = $signed(r[15:0]) % 16'sd30000;
            co_low = $signed(r[31:16]) % 16'sd30000;
            bin_string = r[8:1];
            multi_src = 16'($signed(r[31:28]));
            r = $random(seed);
            xfer_val = (i == 0) ? 16'sd19000 : $signed(r[15:0]) % 16'sd30000;
            e = xfer_val > xfer_max ? xfer_max :
                xfer_val < xfer_min ? xfer_min : xfer_val;
            c = co_ctrl ? co_high : co_low;
            rb = {<<{bin_string}};
            note(4'h3, e);
            note(4'h0, c);
            note(4'h1, {8'h0, rb});
            note(4'h2, multi_src < 0 ? 16'h0 :
                multi_src > 4 ? 16'h4 : multi_src);
            step(1);
        end
        {clk_en, co_high, co_low} = {1'b0, c + 16'sd1, c + 16'sd1};
        note(4'h0, c);
        step(1);
        clk_en = 1'b1;
        note(4'h0, c + 16'sd1);
        step(1);
        defaults_restore = 1'b1;
        step(1);
        defaults_restore = 1'b0;
        note(4'h5, 16'h0001);
        note(4'h4, 16'h0005);
        step(2);
        complete_run();
    end
endmodule
bind dvm_mapper dvm_checker dvm_checker_i (.*);
`default_nettype wire
